// ### core/lin_mode_ctrl.sv
// transceiver mode controller with sample fifo and wake detection

// small fifo carrying received bus samples toward rxd
module lin_sample_fifo #(
	parameter int unsigned WIDTH = lin_mode_pkg::FIFO_WIDTH,
	parameter int unsigned DEPTH = lin_mode_pkg::FIFO_DEPTH
) (
	// clocking
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             clk_en,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// elaboration checks
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("fifo depth must be a power of two of at least two");
	end
	if (WIDTH < 1) begin : g_bad_width
		$error("fifo width must be at least one");
	end

	// storage array
	logic [WIDTH-1:0] mem [DEPTH];

	// all fifo pointer state
	typedef struct packed {
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} fifo_state_t;

	fifo_state_t st;         // registered state
	fifo_state_t next_st;    // next state
	logic        push;       // write this cycle
	logic        pop;        // read this cycle
	logic        full;       // all entries used
	logic        empty;      // no entry held

	// flags from pointer difference
	always_comb begin
		empty     = (st.wr_ptr == st.rd_ptr);
		full      = (st.wr_ptr[AW-1:0] == st.rd_ptr[AW-1:0]) && (st.wr_ptr[AW] != st.rd_ptr[AW]);
		in_ready  = !full;
		out_valid = !empty;
		push      = clk_en && in_valid && !full;
		pop       = clk_en && out_ready && !empty;
		out_data  = mem[st.rd_ptr[AW-1:0]];
		next_st   = st;
		if (push) begin
			next_st.wr_ptr = st.wr_ptr + 1'b1;
		end
		if (pop) begin
			next_st.rd_ptr = st.rd_ptr + 1'b1;
		end
	end

	// pointer register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// data write, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem[st.wr_ptr[AW-1:0]] <= in_data;
		end
	end
endmodule

// top: mode sequencing and pin gating
module lin_mode_ctrl #(
	parameter int unsigned WAKE_CYC     = lin_mode_pkg::WAKE_DOMINANT_CYC,
	parameter int unsigned BLANK_CYC    = lin_mode_pkg::MISMATCH_BLANK_CYC,
	parameter int unsigned FIFO_DEPTH   = lin_mode_pkg::FIFO_DEPTH
) (
	// clocking
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	// supply, regulator and thermal comparators
	input  wire logic supply_on_in,
	input  wire logic supply_off_in,
	input  wire logic regulator_good_in,
	input  wire logic thermal_fault_in,
	// host pins
	input  wire logic select_local_wake_in,
	input  wire logic fault_out_tx_enable_in,
	output logic      fault_out_tx_enable_out,
	output logic      fault_out_tx_enable_oe,
	input  wire logic txd_in,
	output logic      rxd_out,
	output logic      reset_n_out,
	// bus pin and comparators
	input  wire logic bus_level_in,
	input  wire logic bus_below_wake_in,
	output logic      bus_out,
	output logic      bus_oe,
	output logic      bus_pullup_en,
	// analog enables
	output logic      regulator_en,
	output logic      receiver_en,
	output logic      transmitter_en,
	output logic      wake_detect_en,
	// fifo back-pressure seen by the receive path
	output logic      rx_fifo_ready,
	// mode readout
	output lin_mode_pkg::mode_t mode
);
	// elaboration checks
	if (WAKE_CYC < 1 || WAKE_CYC >= (1 << lin_mode_pkg::TIMER_W)) begin : g_bad_wake
		$error("wake count out of timer range");
	end
	if (BLANK_CYC < 1 || BLANK_CYC >= (1 << lin_mode_pkg::TIMER_W)) begin : g_bad_blank
		$error("blank count out of timer range");
	end

	localparam logic [lin_mode_pkg::TIMER_W-1:0] WAKE_LIM  =
		lin_mode_pkg::TIMER_W'(WAKE_CYC);
	localparam logic [lin_mode_pkg::TIMER_W-1:0] BLANK_LIM =
		lin_mode_pkg::TIMER_W'(BLANK_CYC);

	// raw pins gathered for the synchroniser
	lin_mode_pkg::pins_t raw;

	// all controller state
	typedef struct packed {
		lin_mode_pkg::pins_t        sync1;       // first stage, read only by sync2
		lin_mode_pkg::pins_t        sync2;       // settled samples
		lin_mode_pkg::pins_t        prev;        // previous settled samples
		lin_mode_pkg::mode_t        mode;        // current mode
		logic [lin_mode_pkg::TIMER_W-1:0] dom_cnt;   // dominant length in power-down
		logic                       dom_long;    // dominant held long enough
		logic [lin_mode_pkg::TIMER_W-1:0] blank_cnt; // blanking after txd fall
		logic                       mismatch;    // latched contention fault
		logic                       bus_wake;    // last wake came from bus
		logic                       rxd;         // registered receive data
		logic                       bus_drive;   // registered dominant drive
	} ctrl_state_t;

	ctrl_state_t st;          // registered state
	ctrl_state_t next_st;     // next state
	logic        fault_int;   // internal fault present
	logic        txe_eff;     // enable seen as high with no fault
	logic        sel_fall;    // select falling edge
	logic        txe_fall;    // enable falling edge
	logic        txd_fall;    // txd falling edge
	logic        bus_rise;    // bus rising edge
	logic        fifo_valid;  // fifo has a sample
	logic        fifo_data;   // oldest sample
	lin_mode_pkg::enables_t en; // mode enables

	// pins into one bundle
	always_comb begin
		raw.supply_on              = supply_on_in;
		raw.supply_off             = supply_off_in;
		raw.regulator_good         = regulator_good_in;
		raw.select_local_wake_in   = select_local_wake_in;
		raw.fault_out_tx_enable_in = fault_out_tx_enable_in;
		raw.txd                    = txd_in;
		raw.bus_level              = bus_level_in;
		raw.bus_below_wake         = bus_below_wake_in;
	end

	// enables per mode
	always_comb begin
		en = '0;
		case (st.mode)
			lin_mode_pkg::MODE_POR: begin
				en = '0;
			end
			lin_mode_pkg::MODE_READY: begin
				en.regulator_en = 1'b1;
				en.receiver_en  = 1'b1;
				en.reset_n      = st.sync2.regulator_good;
			end
			lin_mode_pkg::MODE_OPERATION: begin
				en.regulator_en   = 1'b1;
				en.receiver_en    = 1'b1;
				en.transmitter_en = st.sync2.regulator_good && !fault_int;
				en.pullup_en      = 1'b1;
				en.reset_n        = st.sync2.regulator_good;
			end
			lin_mode_pkg::MODE_TX_OFF: begin
				en.regulator_en = 1'b1;
				en.receiver_en  = 1'b1;
				en.reset_n      = st.sync2.regulator_good;
			end
			lin_mode_pkg::MODE_POWER_DOWN: begin
				en.wake_detect_en = 1'b1;
			end
			default: begin
				en = '0;
			end
		endcase
	end

	// fault view of the enable pin and edges on settled samples
	always_comb begin
		fault_int = st.mismatch || thermal_fault_in;
		txe_eff   = st.sync2.fault_out_tx_enable_in && !fault_int;
		sel_fall  = st.prev.select_local_wake_in && !st.sync2.select_local_wake_in;
		txe_fall  = st.prev.fault_out_tx_enable_in && !txe_eff;
		txd_fall  = st.prev.txd && !st.sync2.txd;
		bus_rise  = !st.prev.bus_below_wake && st.sync2.bus_below_wake ? 1'b0 :
			(st.prev.bus_below_wake && !st.sync2.bus_below_wake);
	end

	// next state
	always_comb begin
		next_st = st;
		if (clk_en) begin
			next_st.sync1 = raw;
			next_st.sync2 = st.sync1;
			next_st.prev  = st.sync2;
			next_st.prev.fault_out_tx_enable_in = txe_eff;
			// receive data through the fifo, forced recessive when receiver off
			if (fifo_valid) begin
				next_st.rxd = en.receiver_en ? fifo_data : 1'b1;
			end
			next_st.bus_drive = en.transmitter_en && !st.sync2.txd;
			// contention blanking and check
			if (txd_fall) begin
				next_st.blank_cnt = BLANK_LIM;
			end else if (st.blank_cnt != '0) begin
				next_st.blank_cnt = st.blank_cnt - 1'b1;
			end
			// only dominant sent while recessive seen is contention; recessive sent
			// while another node pulls dominant is ordinary reception
			if (st.sync2.select_local_wake_in && en.transmitter_en && st.blank_cnt == '0 &&
				!txd_fall && !st.sync2.txd && st.sync2.bus_level) begin
				next_st.mismatch = 1'b1;
			end else if (st.sync2.txd && st.sync2.bus_level) begin
				next_st.mismatch = 1'b0;
			end
			// wake qualification: long dominant then rising edge
			if (st.mode == lin_mode_pkg::MODE_POWER_DOWN && st.sync2.bus_below_wake) begin
				if (st.dom_cnt >= WAKE_LIM - 1'b1) begin
					next_st.dom_long = 1'b1;
				end else begin
					next_st.dom_cnt = st.dom_cnt + 1'b1;
				end
			end else if (!st.sync2.bus_below_wake) begin
				next_st.dom_cnt  = '0;
				next_st.dom_long = 1'b0;
			end
			// mode transitions
			case (st.mode)
				lin_mode_pkg::MODE_POR: begin
					if (st.sync2.supply_on && !st.sync2.supply_off) begin
						next_st.mode     = lin_mode_pkg::MODE_READY;
						next_st.bus_wake = 1'b0;
					end
				end
				lin_mode_pkg::MODE_READY: begin
					if (st.sync2.regulator_good && st.sync2.select_local_wake_in) begin
						if (txe_eff && st.sync2.txd) begin
							next_st.mode = lin_mode_pkg::MODE_OPERATION;
						end else if (!txe_eff) begin
							next_st.mode = lin_mode_pkg::MODE_TX_OFF;
						end
					end
				end
				lin_mode_pkg::MODE_OPERATION: begin
					if (sel_fall) begin
						next_st.mode = lin_mode_pkg::MODE_POWER_DOWN;
					end else if (txe_fall || !st.sync2.regulator_good) begin
						next_st.mode = lin_mode_pkg::MODE_TX_OFF;
					end
				end
				lin_mode_pkg::MODE_TX_OFF: begin
					if (!st.sync2.select_local_wake_in) begin
						next_st.mode = lin_mode_pkg::MODE_POWER_DOWN;
					end else if (st.sync2.regulator_good && txe_eff && st.sync2.txd) begin
						next_st.mode = lin_mode_pkg::MODE_OPERATION;
					end
				end
				lin_mode_pkg::MODE_POWER_DOWN: begin
					if (st.dom_long && bus_rise) begin
						next_st.mode     = lin_mode_pkg::MODE_READY;
						next_st.bus_wake = 1'b1;
						next_st.dom_long = 1'b0;
						next_st.dom_cnt  = '0;
					end else if (st.sync2.select_local_wake_in) begin
						next_st.mode     = lin_mode_pkg::MODE_READY;
						next_st.bus_wake = 1'b0;
					end
				end
				default: begin
					next_st.mode = lin_mode_pkg::MODE_POR;
				end
			endcase
			if (st.sync2.supply_off) begin
				next_st.mode = lin_mode_pkg::MODE_POR;
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st          <= '0;
			st.mode     <= lin_mode_pkg::MODE_POR;
			st.rxd      <= 1'b1;
			st.sync1.supply_off <= 1'b1;
			st.sync2.supply_off <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// received samples buffered; drained each enabled cycle while the receiver is on
	lin_sample_fifo #(
		.WIDTH (1),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.in_valid  (1'b1),
		.in_ready  (rx_fifo_ready),
		.in_data   (st.sync2.bus_level),
		.out_valid (fifo_valid),
		.out_ready (en.receiver_en),
		.out_data  (fifo_data)
	);

	// outputs
	always_comb begin
		mode           = st.mode;
		rxd_out        = st.rxd;
		bus_out        = 1'b0;
		bus_oe         = st.bus_drive && en.transmitter_en;
		bus_pullup_en  = en.pullup_en;
		regulator_en   = en.regulator_en;
		receiver_en    = en.receiver_en;
		transmitter_en = en.transmitter_en;
		wake_detect_en = en.wake_detect_en;
		reset_n_out    = en.reset_n;
		fault_out_tx_enable_out = 1'b0;
		// open drain: pull low on fault outside power-on reset while select high, or to show bus wake in ready while select low
		if (st.sync2.select_local_wake_in) begin
			fault_out_tx_enable_oe = st.mode != lin_mode_pkg::MODE_POR && fault_int;
		end else begin
			fault_out_tx_enable_oe = st.bus_wake &&
				(st.mode == lin_mode_pkg::MODE_READY);
		end
	end
endmodule

// ### core/lin_mode_pkg.sv
// package: modes, timing constants and carrier structs of the transceiver mode controller
package lin_mode_pkg;

	// clock rate
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS   = 10;

	// wake dominant time, microseconds, least time rounds up
	localparam int unsigned WAKE_DOMINANT_US   = 80;
	localparam int unsigned WAKE_DOMINANT_CYC  =
		(WAKE_DOMINANT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// mismatch report blanking after transmit-data fall, microseconds
	localparam int unsigned MISMATCH_BLANK_US  = 25;
	localparam int unsigned MISMATCH_BLANK_CYC =
		(MISMATCH_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// regulator settle window after wake, microseconds (least / longest)
	localparam int unsigned SETTLE_MIN_US      = 300;
	localparam int unsigned SETTLE_MAX_US      = 1200;
	localparam int unsigned SETTLE_MIN_CYC     =
		(SETTLE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SETTLE_MAX_CYC     = (SETTLE_MAX_US * 1000) / CLK_PERIOD_NS;

	// counter width shared by all timers
	localparam int unsigned TIMER_W            = 18;

	// fifo defaults
	localparam int unsigned FIFO_WIDTH         = 1;
	localparam int unsigned FIFO_DEPTH         = 8;

	// operating modes
	typedef enum logic [2:0] {
		MODE_POR,
		MODE_READY,
		MODE_OPERATION,
		MODE_TX_OFF,
		MODE_POWER_DOWN
	} mode_t;

	// synchronised pin samples
	typedef struct packed {
		logic supply_on;
		logic supply_off;
		logic regulator_good;
		logic select_local_wake_in;
		logic fault_out_tx_enable_in;
		logic txd;
		logic bus_level;
		logic bus_below_wake;
	} pins_t;

	// enables steered by the mode
	typedef struct packed {
		logic transmitter_en;
		logic receiver_en;
		logic regulator_en;
		logic pullup_en;
		logic wake_detect_en;
		logic reset_n;
	} enables_t;

endpackage

// ### dv/lin_bus_partner.sv
// far side: other bus nodes on the wire and the host on the enable pin
module lin_bus_partner #(
	parameter int unsigned PROP_CYC = 2 // wire delay in clocks, less one
) (
	// clocking
	input wire logic clk,
	// device side
	input wire logic bus_oe,
	input wire logic fault_oe,
	// bench commands
	input wire logic remote_dom,
	input wire logic stuck_rec,
	input wire logic host_txe_low,
	// levels seen by the device
	output logic     bus_level,
	output logic     bus_below_wake,
	output logic     fault_pin
);
	logic [PROP_CYC:0] dly = '0; // delayed dominant requests
	// wired-and bus, any driver pulls dominant after the wire delay
	always_ff @(posedge clk) begin
		dly <= {dly[PROP_CYC-1:0], bus_oe | remote_dom};
	end
	// pull-up makes released bus recessive; a short to battery wins
	assign bus_level = stuck_rec | !dly[PROP_CYC];
	assign bus_below_wake = !bus_level;
	// host only pulls low or releases to the pull-up
	assign fault_pin = !(fault_oe | host_txe_low);
endmodule

// ### dv/lin_mode_ctrl_props.sv
// assertion checker on the mode controller ports
module lin_mode_ctrl_props (
	// clocking
	input wire logic                clk,
	input wire logic                sys_rst,
	input wire logic                clk_en,
	// pin inputs
	input wire logic                supply_on_in,
	input wire logic                supply_off_in,
	input wire logic                regulator_good_in,
	input wire logic                select_local_wake_in,
	// outputs
	input wire logic                bus_oe,
	input wire logic                bus_pullup_en,
	input wire logic                regulator_en,
	input wire logic                receiver_en,
	input wire logic                transmitter_en,
	input wire logic                wake_detect_en,
	input wire logic                reset_n_out,
	input wire lin_mode_pkg::mode_t mode
);
	// one clock domain
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	chk_por_all_off: assert property (
		mode == lin_mode_pkg::MODE_POR |-> !regulator_en && !receiver_en && !reset_n_out)
		else $error("enable or reset output active in power-on reset");
	chk_por_holds: assert property (
		(clk_en && !supply_on_in)[*4] ##0 mode == lin_mode_pkg::MODE_POR
		|=> mode == lin_mode_pkg::MODE_POR) else $error("left power-on reset too early");
	chk_ready_enables: assert property (
		mode == lin_mode_pkg::MODE_READY |-> regulator_en && receiver_en && !transmitter_en)
		else $error("ready mode enables wrong");
	chk_ready_stays: assert property (
		(clk_en && !select_local_wake_in && !supply_off_in)[*4]
		##0 mode == lin_mode_pkg::MODE_READY |=> mode == lin_mode_pkg::MODE_READY)
		else $error("left ready with select low");
	chk_pullup_oper: assert property (
		bus_pullup_en == (mode == lin_mode_pkg::MODE_OPERATION))
		else $error("pull-up not tied to operation mode");
	chk_select_low: assert property (
		(clk_en && !select_local_wake_in)[*4] |-> mode != lin_mode_pkg::MODE_OPERATION)
		else $error("operation with select low");
	chk_txoff_enables: assert property (
		mode == lin_mode_pkg::MODE_TX_OFF |-> receiver_en && !transmitter_en)
		else $error("transmitter-off enables wrong");
	chk_reg_bad_txoff: assert property (
		(clk_en && !regulator_good_in)[*4] |-> !transmitter_en
		&& mode != lin_mode_pkg::MODE_OPERATION) else $error("transmit with bad regulator");
	chk_pd_enables: assert property (
		mode == lin_mode_pkg::MODE_POWER_DOWN |-> !regulator_en && !receiver_en
		&& !transmitter_en && wake_detect_en) else $error("power-down enables wrong");
	chk_supply_por: assert property (
		(clk_en && supply_off_in)[*4] |-> mode == lin_mode_pkg::MODE_POR)
		else $error("no power-on reset on low supply");
	chk_drive_gated: assert property (
		bus_oe |-> transmitter_en) else $error("bus driven with transmitter off");

	// main scenarios reached
	cov_fault_off: cover property (
		mode == lin_mode_pkg::MODE_OPERATION ##1 mode == lin_mode_pkg::MODE_TX_OFF);
	cov_wake: cover property (
		mode == lin_mode_pkg::MODE_POWER_DOWN ##1 mode == lin_mode_pkg::MODE_READY);
	cov_drive: cover property (bus_oe);
endmodule

// ### dv/lin_mode_ctrl_test.sv
// self-checking bench for the transceiver mode controller
module lin_mode_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	// compare, count, report
	`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
		$display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end

	// stimulus
	logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
	logic supply_on_in = 1'b0, supply_off_in = 1'b1, regulator_good_in = 1'b0;
	logic thermal_fault_in = 1'b0, select_local_wake_in = 1'b0, txd_in = 1'b1;
	logic remote_dom = 1'b0, stuck_rec = 1'b0, host_txe_low = 1'b0;
	// design outputs and wire levels
	wire logic fault_out_tx_enable_in, bus_level_in, bus_below_wake_in;
	logic fault_out_tx_enable_out, fault_out_tx_enable_oe, rxd_out, reset_n_out;
	logic bus_out, bus_oe, bus_pullup_en, regulator_en, receiver_en;
	logic transmitter_en, wake_detect_en, rx_fifo_ready;
	lin_mode_pkg::mode_t mode;
	int error_cnt = 0;
	int comparisons = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	// short counts for simulation
	lin_mode_ctrl #(.WAKE_CYC(8), .BLANK_CYC(5), .FIFO_DEPTH(8)) i_lin_mode_ctrl (
		.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .supply_on_in(supply_on_in),
		.supply_off_in(supply_off_in), .regulator_good_in(regulator_good_in),
		.thermal_fault_in(thermal_fault_in), .select_local_wake_in(select_local_wake_in),
		.fault_out_tx_enable_in(fault_out_tx_enable_in),
		.fault_out_tx_enable_out(fault_out_tx_enable_out),
		.fault_out_tx_enable_oe(fault_out_tx_enable_oe), .txd_in(txd_in),
		.rxd_out(rxd_out), .reset_n_out(reset_n_out), .bus_level_in(bus_level_in),
		.bus_below_wake_in(bus_below_wake_in), .bus_out(bus_out), .bus_oe(bus_oe),
		.bus_pullup_en(bus_pullup_en), .regulator_en(regulator_en),
		.receiver_en(receiver_en), .transmitter_en(transmitter_en),
		.wake_detect_en(wake_detect_en), .rx_fifo_ready(rx_fifo_ready), .mode(mode));

	// bus nodes and host pin
	lin_bus_partner #(.PROP_CYC(2)) i_lin_bus_partner (
		.clk(clk), .bus_oe(bus_oe), .fault_oe(fault_out_tx_enable_oe),
		.remote_dom(remote_dom), .stuck_rec(stuck_rec), .host_txe_low(host_txe_low),
		.bus_level(bus_level_in), .bus_below_wake(bus_below_wake_in),
		.fault_pin(fault_out_tx_enable_in));

	// step to a later falling edge, where inputs change
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// expected {tx, rx, regulator, pull-up, wake} per mode
	function automatic logic [4:0] exp_en(input lin_mode_pkg::mode_t m);
		case (m)
			lin_mode_pkg::MODE_READY:      return 5'h0c;
			lin_mode_pkg::MODE_OPERATION:  return 5'h1e;
			lin_mode_pkg::MODE_TX_OFF:     return 5'h0c;
			lin_mode_pkg::MODE_POWER_DOWN: return 5'h01;
			default:                       return 5'h00;
		endcase
	endfunction

	// bounded wait for a mode, then compare mode and enables
	task automatic go(input lin_mode_pkg::mode_t m, input int lim);
		int i;
		for (i = 0; i < lim && mode !== m; i++) @(negedge clk);
		`CHK("mode", m, mode)
		`CHK("enables", exp_en(m), {transmitter_en, receiver_en, regulator_en,
			bus_pullup_en, wake_detect_en})
	endtask

	// counts and verdict
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// hang guard, far beyond the roughly one thousand cycles of the tests
	initial begin
		#100000;
		error_cnt++;
		report_and_stop();
	end

	// test sequence
	initial begin
		void'($urandom(68827));
		tick(20);
		sys_rst = 1'b0;
		go(lin_mode_pkg::MODE_POR, 4);
		supply_off_in = 1'b0;
		supply_on_in = 1'b1;
		go(lin_mode_pkg::MODE_READY, 10);
		regulator_good_in = 1'b1;
		tick(20);
		go(lin_mode_pkg::MODE_READY, 1);
		$display("test power_up done");
		host_txe_low = 1'b1;
		select_local_wake_in = 1'b1;
		go(lin_mode_pkg::MODE_TX_OFF, 10);
		host_txe_low = 1'b0;
		go(lin_mode_pkg::MODE_OPERATION, 20);
		$display("test select done");
		// random traffic from both ends, corner of all-recessive last
		repeat (40) begin
			txd_in = 1'($urandom_range(0, 1));
			remote_dom = 1'($urandom_range(0, 1));
			// wire, sync, fifo backlog and rxd register take up to 16 cycles
			tick(20);
			`CHK("rxd", txd_in & !remote_dom, rxd_out)
			`CHK("bus_oe", !txd_in, bus_oe)
			`CHK("bus_out", 1'b0, bus_out)
			`CHK("fault_out", 1'b0, fault_out_tx_enable_out)
			`CHK("fault_oe", 1'b0, fault_out_tx_enable_oe)
			`CHK("fifo_ready", 1'b1, rx_fifo_ready)
		end
		txd_in = 1'b1;
		remote_dom = 1'b0;
		// let the bus settle recessive so the next txd fall is a real edge
		tick(20);
		go(lin_mode_pkg::MODE_OPERATION, 1);
		$display("test traffic done");
		stuck_rec = 1'b1;
		txd_in = 1'b0;
		tick(3);
		`CHK("fault_oe", 1'b0, fault_out_tx_enable_oe)
		go(lin_mode_pkg::MODE_TX_OFF, 30);
		`CHK("fault_oe", 1'b1, fault_out_tx_enable_oe)
		txd_in = 1'b1;
		stuck_rec = 1'b0;
		go(lin_mode_pkg::MODE_OPERATION, 20);
		thermal_fault_in = 1'b1;
		go(lin_mode_pkg::MODE_TX_OFF, 10);
		tick(10);
		go(lin_mode_pkg::MODE_TX_OFF, 1);
		thermal_fault_in = 1'b0;
		go(lin_mode_pkg::MODE_OPERATION, 20);
		regulator_good_in = 1'b0;
		go(lin_mode_pkg::MODE_TX_OFF, 10);
		regulator_good_in = 1'b1;
		go(lin_mode_pkg::MODE_OPERATION, 20);
		$display("test faults done");
		select_local_wake_in = 1'b0;
		go(lin_mode_pkg::MODE_POWER_DOWN, 10);
		tick(20);
		`CHK("fifo_ready", 1'b0, rx_fifo_ready)
		remote_dom = 1'b1;
		tick(4);
		remote_dom = 1'b0;
		tick(10);
		go(lin_mode_pkg::MODE_POWER_DOWN, 1);
		remote_dom = 1'b1;
		tick(12);
		remote_dom = 1'b0;
		go(lin_mode_pkg::MODE_READY, 12);
		tick(2);
		`CHK("fault_oe", 1'b1, fault_out_tx_enable_oe)
		select_local_wake_in = 1'b1;
		go(lin_mode_pkg::MODE_OPERATION, 20);
		select_local_wake_in = 1'b0;
		go(lin_mode_pkg::MODE_POWER_DOWN, 10);
		select_local_wake_in = 1'b1;
		go(lin_mode_pkg::MODE_OPERATION, 20);
		$display("test wake done");
		clk_en = 1'b0;
		select_local_wake_in = 1'b0;
		tick(10);
		go(lin_mode_pkg::MODE_OPERATION, 1);
		clk_en = 1'b1;
		go(lin_mode_pkg::MODE_POWER_DOWN, 10);
		supply_off_in = 1'b1;
		supply_on_in = 1'b0;
		go(lin_mode_pkg::MODE_POR, 10);
		`CHK("reset_n", 1'b0, reset_n_out)
		supply_off_in = 1'b0;
		supply_on_in = 1'b1;
		go(lin_mode_pkg::MODE_READY, 10);
		sys_rst = 1'b1;
		tick(2);
		go(lin_mode_pkg::MODE_POR, 1);
		sys_rst = 1'b0;
		$display("test supply done");
		report_and_stop();
	end
endmodule

// checker on the design top
bind lin_mode_ctrl lin_mode_ctrl_props i_lin_mode_ctrl_props (
	.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .supply_on_in(supply_on_in),
	.supply_off_in(supply_off_in), .regulator_good_in(regulator_good_in),
	.select_local_wake_in(select_local_wake_in), .bus_oe(bus_oe),
	.bus_pullup_en(bus_pullup_en), .regulator_en(regulator_en),
	.receiver_en(receiver_en), .transmitter_en(transmitter_en),
	.wake_detect_en(wake_detect_en), .reset_n_out(reset_n_out), .mode(mode));
